// ### sm_exec_pkg.sv
// Purpose: shared constants for the shift and move execution block
// Assumes: one 8-bit data path, two 16-bit indirect pointers
// Notes: opcode codes are local to this block, not instruction encodings
package sm_exec_pkg;
  localparam int DATA_W = 8;
  localparam int DATA_AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam int PTR_W = 16;
  localparam int REL_W = 6;
  localparam int NUM_PTR = 2;

  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_SHIFT_RIGHT = 3'h1;
  localparam logic [2:0] OP_IND_LOAD = 3'h2;
  localparam logic [2:0] OP_IND_STORE = 3'h3;
  localparam logic [2:0] OP_BANK_LIT = 3'h4;
  localparam logic [2:0] OP_PAGE_LIT = 3'h5;
  localparam logic [2:0] OP_WORK_LIT = 3'h6;
  localparam logic [2:0] OP_WORK_TO_FILE = 3'h7;

  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  localparam logic [6:0] WINDOW0_ADDR = 7'h00;
  localparam logic [6:0] WINDOW1_ADDR = 7'h01;

  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [4:0] BANK_RST = 5'h00;
  localparam logic [6:0] PAGE_RST = 7'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ### data_store_mem.sv
// Purpose: byte-wide data store reached by direct and indirect accesses
// Assumes: one write and one read port, read data registered
// Notes: contents are not reset
`timescale 1ns/1ps
module data_store_mem import sm_exec_pkg::*; (
  input wire logic clk,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [DATA_AW-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [DATA_AW-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end
endmodule

// ### shift_and_move_exec.sv
// Purpose: executes right shift, indirect moves and literal/file moves
// Assumes: each instruction takes two enabled cycles (fetch operand, commit)
// Notes: pointer loads are refused while an instruction is executing
// Behaviour
// - right shift, zero in, bit0 to carry
// - destination bit picks work or file
// - work to file, flags untouched
// - indirect load sets zero, store no flags
// - modes 00/10 access +1/current, pointer increments
// - modes 01/11 access -1/current, pointer decrements
// - relative offset access, pointer unchanged
// - pointers wrap modulo sixteen bits
// - window addresses reach pointer-named location
// - bank literal load, five bits, no flags
// - page latch literal load, seven bits
// - work literal load, eight bits, no flags
// - pointer steps never touch flags
`timescale 1ns/1ps
module shift_and_move_exec import sm_exec_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic instrValid,
  input wire logic [2:0] opcode,
  input wire logic [6:0] fileAddr,
  input wire logic destSel,
  input wire logic [7:0] literal,
  input wire logic ptrSel,
  input wire logic [1:0] updateMode,
  input wire logic relForm,
  input wire logic [REL_W-1:0] relOffset,
  input wire logic ptrLoadEn,
  input wire logic ptrLoadSel,
  input wire logic [PTR_W-1:0] ptrLoadValue,
  output logic instrReady,
  output logic instrDone,
  output logic [DATA_W-1:0] work,
  output logic carry,
  output logic zero,
  output logic [4:0] bankSelect,
  output logic [6:0] pcHighLatch,
  output logic [PTR_W-1:0] pointer0,
  output logic [PTR_W-1:0] pointer1
);
  typedef enum logic {ST_IDLE, ST_EXEC} state_type;

  state_type state;
  state_type next_state;
  logic accept;
  logic commit;
  logic [2:0] opLatch;
  logic destLatch;
  logic [7:0] litLatch;
  logic ptrSelLatch;
  logic [1:0] modeLatch;
  logic relLatch;
  logic [PTR_W-1:0] effAddr;
  logic [PTR_W-1:0] ptrBase;
  logic [PTR_W-1:0] ptrReg [NUM_PTR];
  logic [PTR_W-1:0] ptrCur;
  logic [PTR_W-1:0] next_eff;
  logic indirectIn;
  logic indirectLatch;
  logic [DATA_W-1:0] rdData;
  logic [DATA_W-1:0] shiftRes;
  logic memWe;
  logic [DATA_W-1:0] memWrData;
  logic [DATA_AW-1:0] memRdAddr;

  assign accept = clkEn && instrReady && instrValid;
  assign commit = clkEn && state == ST_EXEC;
  assign indirectIn = opcode == OP_IND_LOAD || opcode == OP_IND_STORE;
  assign indirectLatch = opLatch == OP_IND_LOAD || opLatch == OP_IND_STORE;
  assign ptrCur = ptrSel ? ptrReg[1] : ptrReg[0];
  assign pointer0 = ptrReg[0];
  assign pointer1 = ptrReg[1];

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (instrValid) begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      instrReady <= 1'b1;
      instrDone <= 1'b0;
    end else if (clkEn) begin
      state <= next_state;
      instrReady <= next_state == ST_IDLE;
      instrDone <= state == ST_EXEC;
    end
  end

  // effective address of the operand, from bankSelect[0] and fileAddr, or from the live pointers for indirect and window accesses
  always_comb begin
    next_eff = {8'h00, bankSelect[0], fileAddr};
    if (indirectIn) begin
      if (relForm) begin
        next_eff = ptrCur + {{(PTR_W-REL_W){relOffset[REL_W-1]}}, relOffset};
      end else begin
        case (updateMode)
          MODE_PRE_INC: next_eff = ptrCur + PTR_STEP;
          MODE_PRE_DEC: next_eff = ptrCur - PTR_STEP;
          default: next_eff = ptrCur;
        endcase
      end
    end else if (fileAddr == WINDOW0_ADDR) begin
      next_eff = ptrReg[0];
    end else if (fileAddr == WINDOW1_ADDR) begin
      next_eff = ptrReg[1];
    end
  end

  assign memRdAddr = next_eff[DATA_AW-1:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opLatch <= OP_NOP;
      destLatch <= 1'b0;
      litLatch <= ZERO_BYTE;
      ptrSelLatch <= 1'b0;
      modeLatch <= MODE_PRE_INC;
      relLatch <= 1'b0;
      effAddr <= PTR_RST;
      ptrBase <= PTR_RST;
    end else if (accept) begin
      opLatch <= opcode;
      destLatch <= destSel;
      litLatch <= literal;
      ptrSelLatch <= ptrSel;
      modeLatch <= updateMode;
      relLatch <= relForm;
      effAddr <= next_eff;
      ptrBase <= ptrCur;
    end
  end

  assign shiftRes = {1'b0, rdData[7:1]};
  assign memWe = commit && ((opLatch == OP_SHIFT_RIGHT && destLatch)
    || opLatch == OP_IND_STORE || opLatch == OP_WORK_TO_FILE);
  assign memWrData = opLatch == OP_SHIFT_RIGHT ? shiftRes : work;

  data_store_mem data_store_mem_inst (
    .clk(clk),
    .clkEn(clkEn),
    .wrEn(memWe),
    .wrAddr(effAddr[DATA_AW-1:0]),
    .wrData(memWrData),
    .rdAddr(memRdAddr),
    .rdData(rdData)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      work <= WORK_RST;
    end else if (commit) begin
      case (opLatch)
        OP_SHIFT_RIGHT: begin
          if (!destLatch) begin
            work <= shiftRes;
          end
        end
        OP_IND_LOAD: work <= rdData;
        OP_WORK_LIT: work <= litLatch;
        default: work <= work;
      endcase
    end
  end

  // only the shift and the indirect load touch the flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      carry <= 1'b0;
      zero <= 1'b0;
    end else if (commit) begin
      if (opLatch == OP_SHIFT_RIGHT) begin
        carry <= rdData[0];
        zero <= shiftRes == ZERO_BYTE;
      end else if (opLatch == OP_IND_LOAD) begin
        zero <= rdData == ZERO_BYTE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bankSelect <= BANK_RST;
    end else if (commit && opLatch == OP_BANK_LIT) begin
      bankSelect <= litLatch[4:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pcHighLatch <= PAGE_RST;
    end else if (commit && opLatch == OP_PAGE_LIT) begin
      pcHighLatch <= litLatch[6:0];
    end
  end

  // step from the value seen at accept; a load during execution is refused
  for (genvar i = 0; i < NUM_PTR; i++) begin : g_ptr
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        ptrReg[i] <= PTR_RST;
      end else if (commit && indirectLatch && !relLatch && ptrSelLatch == 1'(i)) begin
        if (modeLatch[0]) begin
          ptrReg[i] <= ptrBase - PTR_STEP;
        end else begin
          ptrReg[i] <= ptrBase + PTR_STEP;
        end
      end else if (clkEn && state == ST_IDLE && ptrLoadEn && ptrLoadSel == 1'(i)) begin
        ptrReg[i] <= ptrLoadValue;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_commit_op(logic [2:0] o);
    commit && opLatch == o;
  endsequence

  sequence s_accept_ind(logic s, logic m);
    accept && indirectIn && !relForm && ptrSel == s && updateMode[0] == m;
  endsequence

  property p_shift_work;
    s_commit_op(OP_SHIFT_RIGHT) ##0 !destLatch |=>
      work == {1'b0, $past(rdData[7:1])} && carry == $past(rdData[0]);
  endproperty
  a_shift_work: assert property (p_shift_work) else $error("shift to work wrong");

  property p_shift_file;
    s_commit_op(OP_SHIFT_RIGHT) ##0 destLatch |->
      memWe && memWrData == {1'b0, rdData[7:1]} ##1 work == $past(work);
  endproperty
  a_shift_file: assert property (p_shift_file) else $error("shift to file wrong");

  property p_work_to_file;
    s_commit_op(OP_WORK_TO_FILE) |-> memWe && memWrData == work
      ##1 carry == $past(carry) && zero == $past(zero);
  endproperty
  a_work_to_file: assert property (p_work_to_file) else $error("work to file wrong");

  property p_store_flags;
    s_commit_op(OP_IND_STORE) |-> memWe ##1 $stable(carry) && $stable(zero);
  endproperty
  a_store_flags: assert property (p_store_flags) else $error("store changed flags");

  property p_load_zero;
    s_commit_op(OP_IND_LOAD) |=>
      work == $past(rdData) && zero == ($past(rdData) == ZERO_BYTE);
  endproperty
  a_load_zero: assert property (p_load_zero) else $error("load zero flag wrong");

  property p_inc_ptr;
    s_accept_ind(1'b0, 1'b0) ##1 commit |=>
      pointer0 == 16'($past(pointer0, 2) + PTR_STEP);
  endproperty
  a_inc_ptr: assert property (p_inc_ptr) else $error("pointer increment wrong");

  property p_dec_ptr;
    s_accept_ind(1'b1, 1'b1) ##1 commit |=>
      pointer1 == 16'($past(pointer1, 2) - PTR_STEP);
  endproperty
  a_dec_ptr: assert property (p_dec_ptr) else $error("pointer decrement wrong");

  property p_pre_addr;
    accept && indirectIn && !relForm && !ptrSel && updateMode == MODE_PRE_INC |->
      memRdAddr == 8'(pointer0 + PTR_STEP);
  endproperty
  a_pre_addr: assert property (p_pre_addr) else $error("pre-increment address wrong");

  property p_rel_hold;
    accept && indirectIn && relForm ##1 commit |=>
      pointer0 == $past(pointer0, 2) && pointer1 == $past(pointer1, 2);
  endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("relative form moved pointer");

  property p_window;
    accept && !indirectIn && fileAddr == WINDOW1_ADDR |-> memRdAddr == pointer1[7:0];
  endproperty
  a_window: assert property (p_window) else $error("window not redirected");

  property p_bank_lit;
    s_commit_op(OP_BANK_LIT) |=>
      bankSelect == $past(litLatch[4:0]) && $stable(carry) && $stable(zero);
  endproperty
  a_bank_lit: assert property (p_bank_lit) else $error("bank literal wrong");

  property p_page_lit;
    s_commit_op(OP_PAGE_LIT) |=> pcHighLatch == $past(litLatch[6:0]) && $stable(zero);
  endproperty
  a_page_lit: assert property (p_page_lit) else $error("page literal wrong");

  property p_work_lit;
    s_commit_op(OP_WORK_LIT) |=> work == $past(litLatch) && $stable(carry);
  endproperty
  a_work_lit: assert property (p_work_lit) else $error("work literal wrong");
endmodule

// ### shift_and_move_exec_tb_top.sv
// Purpose: self-checking bench for the shift and move execution block
// Assumes: clkEn held high, one instruction in flight at a time
// Notes: memory is preloaded through stores, since its contents start unknown
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module shift_and_move_exec_tb_top import sm_exec_pkg::*;;
  logic clk = 0, rst_n = 0, clkEn = 1, instrValid = 0, destSel = 0;
  logic ptrSel = 0, relForm = 0, ptrLoadEn = 0, ptrLoadSel = 0;
  logic [2:0] opcode = 3'h0;
  logic [6:0] fileAddr = 7'h00;
  logic [7:0] literal = 8'h00;
  logic [1:0] updateMode = 2'h0;
  logic [REL_W-1:0] relOffset = 6'h00;
  logic [PTR_W-1:0] ptrLoadValue = 16'h0000;
  logic instrReady, instrDone, carry, zero;
  logic [DATA_W-1:0] work;
  logic [4:0] bankSelect;
  logic [6:0] pcHighLatch;
  logic [PTR_W-1:0] pointer0, pointer1;
  int fail_count = 0;
  int check_count = 0;

  shift_and_move_exec shift_and_move_exec_inst (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .instrValid(instrValid), .opcode(opcode), .fileAddr(fileAddr), .destSel(destSel),
    .literal(literal), .ptrSel(ptrSel), .updateMode(updateMode), .relForm(relForm),
    .relOffset(relOffset), .ptrLoadEn(ptrLoadEn), .ptrLoadSel(ptrLoadSel),
    .ptrLoadValue(ptrLoadValue), .instrReady(instrReady), .instrDone(instrDone),
    .work(work), .carry(carry), .zero(zero), .bankSelect(bankSelect),
    .pcHighLatch(pcHighLatch), .pointer0(pointer0), .pointer1(pointer1));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // bounded wait on a handshake flag; running out ends the run
  task automatic waitFor(input string nm, input bit forDone);
    int n;
    n = 0;
    while ((forDone ? instrDone : instrReady) !== 1'b1) begin
      if (n++ > 20) begin
        fail_count++;
        $display("Error %s expected 1 seen %b", nm, forDone ? instrDone : instrReady);
        final_report();
      end
      @(posedge clk);
      #1;
    end
  endtask

  task automatic ex(input logic [2:0] op, input logic [6:0] fa, input logic d,
                    input logic [7:0] lit, input logic ps, input logic [1:0] md,
                    input logic rf, input logic [5:0] off);
    waitFor("instrReady", 1'b0);
    opcode = op;
    fileAddr = fa;
    destSel = d;
    literal = lit;
    ptrSel = ps;
    updateMode = md;
    relForm = rf;
    relOffset = off;
    instrValid = 1'b1;
    @(posedge clk);
    #1;
    instrValid = 1'b0;
    waitFor("instrDone", 1'b1);
  endtask

  task automatic lit(input logic [2:0] op, input logic [7:0] v);
    ex(op, 7'h00, 1'b0, v, 1'b0, 2'h0, 1'b0, 6'h00);
  endtask

  task automatic fop(input logic [2:0] op, input logic [6:0] a, input logic d);
    ex(op, a, d, 8'h00, 1'b0, 2'h0, 1'b0, 6'h00);
  endtask

  task automatic ind(input logic [2:0] op, input logic s, input logic [1:0] md,
                     input logic rf, input logic [5:0] off);
    ex(op, 7'h00, 1'b0, 8'h00, s, md, rf, off);
  endtask

  task automatic pload(input logic s, input logic [15:0] v);
    waitFor("instrReady", 1'b0);
    ptrLoadSel = s;
    ptrLoadValue = v;
    ptrLoadEn = 1'b1;
    @(posedge clk);
    #1;
    ptrLoadEn = 1'b0;
  endtask

  task automatic tReset;
    `CHK("resetState", 8'h00, {instrReady, instrDone, carry, zero, work[3:0]} ^ 8'h80)
    `CHK("resetRegs", 52'h0, {work, bankSelect, pcHighLatch, pointer0, pointer1})
  endtask

  task automatic tLiterals;
    lit(OP_WORK_LIT, 8'h01);
    fop(OP_WORK_TO_FILE, 7'h20, 1'b0);
    fop(OP_SHIFT_RIGHT, 7'h20, 1'b0);
    `CHK("shiftOne", 10'h003, {work, carry, zero})
    lit(OP_WORK_LIT, 8'hFF);
    `CHK("workLit", 10'h3FF, {work, carry, zero})
    lit(OP_BANK_LIT, 8'h15);
    `CHK("bankLit", 7'h57, {bankSelect, carry, zero})
    lit(OP_PAGE_LIT, 8'h6B);
    `CHK("pageLit", 9'h1AF, {pcHighLatch, carry, zero})
    lit(OP_BANK_LIT, 8'h00);
  endtask

  task automatic tShift;
    lit(OP_WORK_LIT, 8'hB6);
    fop(OP_WORK_TO_FILE, 7'h30, 1'b0);
    `CHK("fileMoveFlags", 2'b11, {carry, zero})
    fop(OP_SHIFT_RIGHT, 7'h30, 1'b1);
    `CHK("shiftToFile", 10'h2D8, {work, carry, zero})
    fop(OP_SHIFT_RIGHT, 7'h30, 1'b0);
    `CHK("shiftToWork", 10'h0B6, {work, carry, zero})
  endtask

  task automatic tIndirect;
    pload(1'b0, 16'h0030);
    ind(OP_IND_LOAD, 1'b0, MODE_POST_INC, 1'b0, 6'h00);
    `CHK("postInc", 26'h16D_0031, {work, zero, carry, pointer0})
    ind(OP_IND_LOAD, 1'b0, MODE_PRE_DEC, 1'b0, 6'h00);
    `CHK("preDec", 24'h5B_0030, {work, pointer0})
    lit(OP_WORK_LIT, 8'h00);
    ind(OP_IND_STORE, 1'b0, MODE_PRE_INC, 1'b0, 6'h00);
    `CHK("storeFlags", 18'h1_0031, {zero, carry, pointer0})
    ind(OP_IND_LOAD, 1'b0, MODE_POST_DEC, 1'b0, 6'h00);
    `CHK("postDec", 26'h003_0030, {work, zero, carry, pointer0})
    lit(OP_WORK_LIT, 8'h77);
    ind(OP_IND_STORE, 1'b0, 2'h0, 1'b1, 6'h20);
    `CHK("relPointer", 16'h0030, pointer0)
    pload(1'b1, 16'h0010);
    lit(OP_WORK_LIT, 8'h00);
    ind(OP_IND_LOAD, 1'b1, MODE_PRE_DEC, 1'b1, 6'h00);
    `CHK("relRead", 25'h0EE_0010, {work, zero, pointer1})
  endtask

  task automatic tWrap;
    pload(1'b1, 16'hFFFF);
    lit(OP_WORK_LIT, 8'h3C);
    ind(OP_IND_STORE, 1'b1, MODE_PRE_INC, 1'b0, 6'h00);
    `CHK("wrapUp", 17'h1_0000, {carry, pointer1})
    lit(OP_WORK_LIT, 8'h00);
    ind(OP_IND_LOAD, 1'b1, MODE_POST_DEC, 1'b0, 6'h00);
    `CHK("wrapDown", 25'h078_FFFF, {work, zero, pointer1})
  endtask

  task automatic tWindow;
    pload(1'b0, 16'h0040);
    lit(OP_WORK_LIT, 8'h81);
    fop(OP_WORK_TO_FILE, WINDOW0_ADDR, 1'b0);
    lit(OP_WORK_LIT, 8'h00);
    fop(OP_SHIFT_RIGHT, WINDOW0_ADDR, 1'b0);
    `CHK("windowShift", 10'h102, {work, carry, zero})
    ind(OP_IND_LOAD, 1'b0, MODE_POST_INC, 1'b0, 6'h00);
    `CHK("windowStore", 24'h81_0041, {work, pointer0})
    pload(1'b1, 16'h0040);
    fop(OP_SHIFT_RIGHT, WINDOW1_ADDR, 1'b1);
    ind(OP_IND_LOAD, 1'b0, MODE_PRE_DEC, 1'b0, 6'h00);
    `CHK("window1Shift", 26'h102_0040, {work, carry, zero, pointer0})
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1;
    tReset();
    rst_n = 1'b1;
    tLiterals();
    tShift();
    tIndirect();
    tWrap();
    tWindow();
    final_report();
  end
endmodule
